/* logic/arc_device.sv */
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - rom read starts conversion, shows previous word
// - next word read returns new result
// - host spaces rom reads conversion plus gap
// - byte reads use low eight outputs, low first
// - first byte rom read behaves like word read
// - host waits conversion time after start
// - high byte read: msbs low, next four zero
// - third byte read returns low, restarts
// - msbs always on top four when driven
// - slow byte read returns low after conversion
// - high byte select returns high byte
// - busy low for entire conversion
// - high byte read never asserts busy
// - start and enables may lag one cycle; here busy and drive follow the strobes three cycles later
// - host clock shared with converter clock
// - host drives byte select from address; here the host sequencer raises it for the high byte read
// - start only when all three inputs low
// - starts ignored while converting
// - right justified natural binary result
module arc_device (
	input wire logic i_ref_clk, // converter clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_ce, // clock enable
	input wire logic [arc_pkg::DATA_W-1:0] i_sample, // analog sample, as a code
	output logic o_sample_strobe, // pulse when sample is taken
	arc_if.device bus // host port
);
	logic [1:0] cs_sync;
	logic [1:0] rd_sync;
	logic [1:0] hb_sync;
	logic start_req;
	logic access;
	logic converting;
	logic [arc_pkg::CNT_W-1:0] count;
	logic [arc_pkg::DATA_W-1:0] result;
	logic [arc_pkg::DATA_W-1:0] held;
	logic start_seen;
	logic [arc_pkg::DATA_W-1:0] next_drive;
	logic [arc_pkg::DATA_W-1:0] shown;
	logic finishing;

	// last counted cycle of a conversion; latch, busy and mux all share it
	function automatic logic conv_last(input logic run, input logic [arc_pkg::CNT_W-1:0] cnt);
		conv_last = run && (cnt == arc_pkg::CNT_ONE);
	endfunction : conv_last

	// high byte layout: msbs on the low nibble, zeros, msbs again on top
	function automatic logic [arc_pkg::DATA_W-1:0] high_view(
		input logic [arc_pkg::DATA_W-1:0] word
	);
		high_view = {word[11:8], arc_pkg::NIB_LOW, word[11:8]};
	endfunction : high_view

	// pins from the host pass two flops; adds a two-cycle lag
	always_ff @(posedge i_ref_clk or negedge i_nrst)
		if (!i_nrst)
		begin
			cs_sync <= 2'h3;
			rd_sync <= 2'h3;
			hb_sync <= 2'h0;
		end
		else if (i_ce)
		begin
			cs_sync <= {cs_sync[0], bus.cs_n};
			rd_sync <= {rd_sync[0], bus.rd_n};
			hb_sync <= {hb_sync[0], bus.high_byte_select};
		end

	assign access = !cs_sync[1] && !rd_sync[1];
	// a start needs all three low, ignored while converting
	assign start_req = access && !hb_sync[1] && !converting && !start_seen;

	// one flag decides the last cycle, so latch and busy cannot drift apart
	assign finishing = conv_last(converting, count);

	// one start per access; held until the strobe goes away
	// a long strobe would otherwise restart once the conversion ends
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			start_seen <= 1'b0;
		end
		else if (i_ce)
		begin
			start_seen <= access && (start_seen || start_req);
		end
	end

	// conversion timer; busy follows it
	// a start while running is refused silently, as the pins have no error path
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			converting <= 1'b0;
			count <= arc_pkg::CNT_ZERO;
		end
		else if (i_ce)
		begin
			if (start_req)
			begin
				converting <= 1'b1;
				count <= arc_pkg::CONV_COUNT;
			end
			else if (converting)
			begin
				count <= count - 1'b1;
				if (finishing)
				begin
					converting <= 1'b0;
				end
			end
		end
	end

	// sample taken at start, result latched at the end
	// the held code stands in for the sample-and-hold capacitor
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			held <= arc_pkg::RESULT_RST;
			result <= arc_pkg::RESULT_RST;
		end
		else if (i_ce)
		begin
			if (start_req)
			begin
				held <= i_sample;
			end
			if (finishing)
			begin
				result <= held;
			end
		end
	end

	// sampling instant, for whoever feeds the sample code
	assign o_sample_strobe = start_req && i_ce;

	// output mux: word or low byte, or high byte with msbs mirrored
	// rom old data and slow new data both fall out of the latch timing
	// the finishing word is forwarded so data is new when busy rises
	always_comb
	begin
		shown = result;
		if (finishing)
		begin
			shown = held;
		end
		next_drive = shown;
		if (hb_sync[1])
		begin
			next_drive = high_view(shown);
		end
	end

	// registered data pins; after the two sync flops, data follows the strobes three cycles later, past the one-cycle lag allowed
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			bus.data_o <= arc_pkg::RESULT_RST;
		end
		else if (i_ce)
		begin
			bus.data_o <= next_drive;
		end
	end

	// drivers only during an access
	// drive follows the synchronised strobe, so it never outlives the access long
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			bus.data_oe <= 12'h000;
		end
		else if (i_ce)
		begin
			bus.data_oe <= access ? 12'hFFF : 12'h000;
		end
	end

	// busy low from the cycle after the start through the last counted cycle
	// high byte reads never start, so they never pull busy down
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			bus.busy_n <= 1'b1;
		end
		else if (i_ce)
		begin
			bus.busy_n <= !(start_req || (converting && !finishing));
		end
	end
endmodule : arc_device
`default_nettype wire

/* logic/arc_host.sv */
`timescale 1ns/1ns
`default_nettype none
// host end: one command reads a word or two bytes in slow or rom mode
module arc_host (
	input wire logic i_ref_clk, // shared clock, synchronous to converter
	input wire logic i_nrst, // async reset, active low
	input wire logic i_ce, // clock enable
	input wire logic i_req, // read request pulse
	input wire logic i_byte_mode, // 1: two byte read
	input wire logic i_rom_mode, // 1: no wait on busy
	output logic o_ready, // may take a request
	output logic o_done, // result valid pulse
	output logic [arc_pkg::DATA_W-1:0] o_result, // assembled result
	arc_if.host bus // converter port
);
	arc_pkg::arc_host_state_t state;
	logic [arc_pkg::CNT_W-1:0] gap;
	logic [arc_pkg::CNT_W-1:0] hold;
	logic byte_mode;
	logic rom_mode;
	logic [1:0] busy_sync;
	// covers two flops each way plus the registered busy, so busy is seen settled
	localparam logic [arc_pkg::CNT_W-1:0] HOLD_COUNT = 12'h005;

	// busy is a pin, so two flops before use
	always_ff @(posedge i_ref_clk or negedge i_nrst)
		if (!i_nrst)
			busy_sync <= 2'h3;
		else if (i_ce)
			busy_sync <= {busy_sync[0], bus.busy_n};

	assign o_ready = (state == arc_pkg::ARC_IDLE) && gap == arc_pkg::CNT_ZERO;

	// strobe the converter; hold covers synchroniser lag
	always_ff @(posedge i_ref_clk or negedge i_nrst)
		if (!i_nrst)
		begin
			state <= arc_pkg::ARC_IDLE;
			bus.cs_n <= 1'b1;
			bus.rd_n <= 1'b1;
			bus.high_byte_select <= 1'b0;
			gap <= arc_pkg::CNT_ZERO;
			hold <= arc_pkg::CNT_ZERO;
			byte_mode <= 1'b0;
			rom_mode <= 1'b0;
			o_done <= 1'b0;
			o_result <= arc_pkg::RESULT_RST;
		end
		else if (i_ce)
		begin
			o_done <= 1'b0;
			if (gap != arc_pkg::CNT_ZERO)
				gap <= gap - 1'b1;
			unique case (state)
				arc_pkg::ARC_IDLE:
					if (i_req && o_ready)
					begin
						byte_mode <= i_byte_mode;
						rom_mode <= i_rom_mode;
						bus.cs_n <= 1'b0;
						bus.rd_n <= 1'b0;
						bus.high_byte_select <= 1'b0;
						hold <= HOLD_COUNT;
						state <= arc_pkg::ARC_LOW;
					end
				arc_pkg::ARC_LOW:
					if (hold != arc_pkg::CNT_ZERO)
						hold <= hold - 1'b1;
					else if (rom_mode || busy_sync[1])
					begin
						bus.cs_n <= 1'b1;
						bus.rd_n <= 1'b1;
						o_result <= byte_mode ? {o_result[11:8], bus.data[7:0]} : bus.data;
						// rom spacing covers conversion plus reacquisition
						gap <= arc_pkg::ROM_GAP_COUNT;
						state <= byte_mode ? arc_pkg::ARC_GAP : arc_pkg::ARC_IDLE;
						o_done <= !byte_mode;
					end
				arc_pkg::ARC_GAP:
					if (!rom_mode || gap <= arc_pkg::REACQ_CYCLES[11:0])
					begin
						// high byte access, no conversion, no wait
						bus.cs_n <= 1'b0;
						bus.rd_n <= 1'b0;
						bus.high_byte_select <= 1'b1;
						hold <= HOLD_COUNT;
						state <= arc_pkg::ARC_HIGH;
					end
				arc_pkg::ARC_HIGH:
					if (hold != arc_pkg::CNT_ZERO)
						hold <= hold - 1'b1;
					else
					begin
						bus.cs_n <= 1'b1;
						bus.rd_n <= 1'b1;
						bus.high_byte_select <= 1'b0;
						o_result <= {bus.data[3:0], o_result[7:0]};
						o_done <= 1'b1;
						state <= arc_pkg::ARC_IDLE;
					end
				default:
					state <= arc_pkg::ARC_IDLE;
			endcase
		end
endmodule : arc_host
`default_nettype wire

/* logic/arc_if.sv */
`timescale 1ns/1ns
`default_nettype none
// parallel host port between converter and host
interface arc_if;
	logic cs_n;
	logic rd_n;
	logic high_byte_select;
	logic busy_n;
	logic [arc_pkg::DATA_W-1:0] data_o;
	logic [arc_pkg::DATA_W-1:0] data_oe;
	// resolved data bus level, undriven bits read as 0
	logic [arc_pkg::DATA_W-1:0] data;
	assign data = data_o & data_oe;
	modport device (input cs_n, rd_n, high_byte_select, output busy_n, data_o, data_oe);
	modport host (output cs_n, rd_n, high_byte_select, input busy_n, data);
endinterface : arc_if
`default_nettype wire

/* logic/arc_pkg.sv */
`default_nettype none
package arc_pkg;
	localparam int DATA_W = 12;
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int CLK_PERIOD_NS = 8;
	// conversion time of the converter model, in ns
	localparam int CONV_TIME_NS = 3000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// reacquisition gap between conversions, in ns
	localparam int REACQ_TIME_NS = 1000;
	localparam int REACQ_CYCLES = (REACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] CONV_COUNT = CNT_W'(CONV_CYCLES);
	localparam logic [CNT_W-1:0] ROM_GAP_COUNT = CNT_W'(CONV_CYCLES + REACQ_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
	// count value seen in the last cycle of a conversion
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
	localparam logic [DATA_W-1:0] RESULT_RST = 12'h000;
	localparam logic [NIB_W-1:0] NIB_LOW = 4'h0;
	// host sequencer states
	typedef enum logic [3:0] {
		ARC_IDLE = 4'b0001,
		ARC_LOW = 4'b0010,
		ARC_GAP = 4'b0100,
		ARC_HIGH = 4'b1000
	} arc_host_state_t;
endpackage : arc_pkg
`default_nettype wire

/* test/arc_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// watches the host port where both ends meet
module arc_properties (
	input wire logic i_ref_clk, // shared clock
	input wire logic i_nrst, // async reset, active low
	input wire logic cs_n, // chip select
	input wire logic rd_n, // read strobe
	input wire logic high_byte_select, // byte select
	input wire logic busy_n, // low while converting
	input wire logic [arc_pkg::DATA_W-1:0] data_o, // device data
	input wire logic [arc_pkg::DATA_W-1:0] data_oe // device drive enable
);
	logic [11:0] busy_cnt;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	// low cycles of the running conversion, so length is exact
	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst || busy_n)
			busy_cnt <= 12'h000;
		else
			busy_cnt <= busy_cnt + 12'h001;
	end
	AST_START_ALL_LOW:
	assert property ($fell(busy_n) |-> !$past(cs_n, 2) && !$past(rd_n, 2)
		&& !$past(high_byte_select, 2)) else $error("start without all selects low");
	AST_BUSY_LENGTH:
	assert property ($rose(busy_n) |-> busy_cnt == arc_pkg::CONV_CYCLES)
		else $error("busy low for wrong length");
	AST_NO_RESTART:
	assert property (!busy_n |-> busy_cnt < arc_pkg::CONV_CYCLES) else $error("busy extended");
	AST_LOW_READ_STARTS:
	assert property (!cs_n && !rd_n && !high_byte_select && busy_n && ($past(cs_n) || $past(rd_n))
		|-> ##[1:6] !busy_n) else $error("low read did not start");
	AST_HIGH_NO_BUSY:
	assert property (!cs_n && !rd_n && high_byte_select && busy_n && ($past(cs_n) || $past(rd_n))
		|-> busy_n [*4]) else $error("high read raised busy");
	AST_IDLE_HIGH_Z:
	assert property ((cs_n || rd_n) [*6] |-> data_oe == 12'h000) else $error("driven while idle");
	AST_HIGH_MUX:
	assert property (high_byte_select && $past(high_byte_select, 3) && (|data_oe)
		|-> data_o[7:4] == 4'h0 && data_o[3:0] == data_o[11:8]) else $error("bad high byte");
	AST_BUSY_WITH_DRIVE:
	assert property ($fell(busy_n) |-> ##[0:1] data_oe == 12'hFFF) else $error("no drive");
	// main scenarios seen
	CV_CONV: cover property ($rose(busy_n));
	CV_HIGH: cover property (high_byte_select && !cs_n && !rd_n);
	CV_IDLE: cover property ($fell(cs_n) && busy_n);
endmodule : arc_properties
`default_nettype wire

/* test/tb_adc_read_convert_interface.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_adc_read_convert_interface;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_req = 1'b0;
	logic i_byte_mode = 1'b0;
	logic i_rom_mode = 1'b0;
	logic [arc_pkg::DATA_W-1:0] i_sample = 12'h000;
	logic o_ready;
	logic o_done;
	logic [arc_pkg::DATA_W-1:0] o_result;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	arc_if arc_if_i ();
	arc_device arc_device_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(1'b1),
		.i_sample(i_sample), .o_sample_strobe(), .bus(arc_if_i.device));
	arc_host arc_host_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_req(i_req),
		.i_byte_mode(i_byte_mode), .i_rom_mode(i_rom_mode), .o_ready(o_ready),
		.o_done(o_done), .o_result(o_result), .bus(arc_if_i.host));
	arc_properties arc_properties_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
		.cs_n(arc_if_i.cs_n), .rd_n(arc_if_i.rd_n), .high_byte_select(arc_if_i.high_byte_select),
		.busy_n(arc_if_i.busy_n), .data_o(arc_if_i.data_o), .data_oe(arc_if_i.data_oe));
	// 125 MHz clock, shared by host and converter
	initial forever #4 i_ref_clk = ~i_ref_clk;
	// hang guard, far above the six commands
	always @(posedge i_ref_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			errors++;
			final_report();
		end
	end
	task final_report;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	// one host command, then the spacing the converter needs
	task do_read(input logic bm, input logic rm, input logic [arc_pkg::DATA_W-1:0] smp);
		int n;
		n = 0;
		@(negedge i_ref_clk);
		while (o_ready !== 1'b1 && n < 2000)
		begin
			@(negedge i_ref_clk);
			n++;
		end
		i_sample = smp;
		i_byte_mode = bm;
		i_rom_mode = rm;
		i_req = 1'b1;
		@(negedge i_ref_clk);
		i_req = 1'b0;
		while (o_done !== 1'b1 && n < 4000)
		begin
			@(negedge i_ref_clk);
			n++;
		end
		if (n >= 4000)
			errors++;
		repeat (arc_pkg::CONV_CYCLES + arc_pkg::REACQ_CYCLES) @(negedge i_ref_clk);
	endtask : do_read
	// main sequence
	initial
	begin
		repeat (2) @(negedge i_ref_clk);
		`CHK(arc_if_i.data, 12'h000)
		i_nrst = 1'b1;
		do_read(1'b0, 1'b0, 12'hA5C);
		`CHK(o_result, 12'hA5C)
		do_read(1'b1, 1'b0, 12'h3B7);
		`CHK(o_result, 12'h3B7)
		do_read(1'b0, 1'b1, 12'h5E1);
		`CHK(o_result, 12'h3B7)
		do_read(1'b0, 1'b1, 12'h0F2);
		`CHK(o_result, 12'h5E1)
		do_read(1'b1, 1'b1, 12'hC3D);
		`CHK(o_result[11:8], 4'hC)
		`CHK(o_result[7:0], 8'hF2)
		do_read(1'b1, 1'b1, 12'h7E4);
		`CHK(o_result[11:8], 4'h7)
		`CHK(o_result[7:0], 8'h3D)
		`CHK(arc_if_i.data, 12'h000)
		final_report();
	end
endmodule : tb_adc_read_convert_interface
`default_nettype wire
